// ---- inc/imc_pkg.sv ----
// package: constants, register map and carrier types for the input mapping and mode control block
package imc_pkg;
   localparam int unsigned NUM_CH = 8;
   // register byte offsets
   localparam logic [7:0] OFF_CHAN_DRIVE = 8'h00;
   localparam logic [7:0] OFF_IN0_MAP = 8'h04;
   localparam logic [7:0] OFF_IN1_MAP = 8'h08;
   localparam logic [7:0] OFF_IN_LEVEL = 8'h0C;
   localparam logic [7:0] OFF_MODE_STAT = 8'h10;
   // reset values
   localparam logic [7:0] RST_CHAN_DRIVE = 8'h00;
   localparam logic [7:0] RST_IN0_MAP = 8'h04;
   localparam logic [7:0] RST_IN1_MAP = 8'h08;
   // mode status field positions
   localparam int unsigned MS_MODE_LSB = 0;
   localparam int unsigned MS_BUS_OK = 2;
   localparam int unsigned MS_UV_EN = 3;
   localparam int unsigned MS_BAT_OK = 4;
   localparam logic [31:0] ERR_DATA = 32'h0000_0000;

   typedef enum logic [1:0]
   {
      MODE_ACTIVE = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_FAILSAFE = 2'b10
   } imc_mode_t;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } imc_apb_req_t;

   typedef struct packed
   {
      logic prdata_dummy;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } imc_apb_rsp_t;

   typedef struct packed
   {
      logic batt_uv;
      logic batt_op;
      logic logic_uv;
   } imc_supply_t;
endpackage : imc_pkg

// ---- core/imc_core.sv ----
// module: direct input mapping, mode control and supply gating with an APB register file
`timescale 1ns/1ps
module imc_core
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire imc_pkg::imc_apb_req_t apb_req_i,
   output imc_pkg::imc_apb_rsp_t apb_rsp_o,
   input wire logic direct_input_0_i,
   input wire logic direct_input_1_i,
   input wire logic low_power_req_i,
   input wire imc_pkg::imc_supply_t supply_i,
   output logic [7:0] chan_drive_o,
   output imc_pkg::imc_mode_t mode_o,
   output logic uv_detect_en_o,
   output logic serial_out_en_o
);
   ////////////////////////////////////////////////////////////////////////////
   // synchronisers
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   logic [2:0] sup_meta_reg;
   logic [2:0] sup_sync_reg;
   logic in0;
   logic in1;
   logic lp_req;
   logic batt_uv;
   logic batt_op;
   logic logic_uv;

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pin_meta_reg <= 3'h4;
         pin_sync_reg <= 3'h4;
         sup_meta_reg <= 3'h0;
         sup_sync_reg <= 3'h0;
      end
      else
      begin
         pin_meta_reg <= {low_power_req_i, direct_input_1_i, direct_input_0_i};
         pin_sync_reg <= pin_meta_reg;
         sup_meta_reg <= {supply_i.batt_uv, supply_i.batt_op, supply_i.logic_uv};
         sup_sync_reg <= sup_meta_reg;
      end
   end

   assign in0 = pin_sync_reg[0];
   assign in1 = pin_sync_reg[1];
   assign lp_req = pin_sync_reg[2];
   assign batt_uv = sup_sync_reg[2];
   assign batt_op = sup_sync_reg[1];
   assign logic_uv = sup_sync_reg[0];

   ////////////////////////////////////////////////////////////////////////////
   // mode decision
   imc_pkg::imc_mode_t mode_next;
   logic sleep_req;
   logic uv_en;
   logic regs_clear;
   logic bus_ok;

   always_comb
   begin
      case ({lp_req, in0 | in1})
         2'b00: mode_next = imc_pkg::MODE_SLEEP;
         2'b01: mode_next = imc_pkg::MODE_FAILSAFE;
         2'b10: mode_next = imc_pkg::MODE_ACTIVE;
         2'b11: mode_next = imc_pkg::MODE_ACTIVE;
         default: mode_next = imc_pkg::MODE_ACTIVE;
      endcase
   end

   assign sleep_req = (mode_next == imc_pkg::MODE_SLEEP);
   assign uv_en = !sleep_req;
   assign regs_clear = !lp_req || (uv_en && logic_uv);
   assign bus_ok = !sleep_req && !(uv_en && logic_uv);

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_o <= imc_pkg::MODE_ACTIVE;
         uv_detect_en_o <= 1'b1;
         serial_out_en_o <= 1'b0;
      end
      else
      begin
         mode_o <= mode_next;
         uv_detect_en_o <= uv_en;
         serial_out_en_o <= bus_ok && apb_req_i.psel && !apb_req_i.pwrite;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file
   logic [7:0] chan_reg;
   logic [7:0] map0_reg;
   logic [7:0] map1_reg;
   logic acc;
   logic rdy_reg;
   logic wr_acc;
   logic mapped;

   assign acc = apb_req_i.psel && apb_req_i.penable;
   // write lands only at the edge that sees pready high
   assign wr_acc = acc && rdy_reg && apb_req_i.pwrite && bus_ok;
   assign mapped = (apb_req_i.paddr == imc_pkg::OFF_CHAN_DRIVE) || (apb_req_i.paddr == imc_pkg::OFF_IN0_MAP)
      || (apb_req_i.paddr == imc_pkg::OFF_IN1_MAP) || (apb_req_i.paddr == imc_pkg::OFF_IN_LEVEL)
      || (apb_req_i.paddr == imc_pkg::OFF_MODE_STAT);

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         chan_reg <= imc_pkg::RST_CHAN_DRIVE;
         map0_reg <= imc_pkg::RST_IN0_MAP;
         map1_reg <= imc_pkg::RST_IN1_MAP;
      end
      else if (regs_clear)
      begin
         chan_reg <= imc_pkg::RST_CHAN_DRIVE;
         map0_reg <= imc_pkg::RST_IN0_MAP;
         map1_reg <= imc_pkg::RST_IN1_MAP;
      end
      else if (wr_acc)
      begin
         if (apb_req_i.paddr == imc_pkg::OFF_CHAN_DRIVE)
            chan_reg <= apb_req_i.pwdata[7:0];
         if (apb_req_i.paddr == imc_pkg::OFF_IN0_MAP)
            map0_reg <= apb_req_i.pwdata[7:0];
         if (apb_req_i.paddr == imc_pkg::OFF_IN1_MAP)
            map1_reg <= apb_req_i.pwdata[7:0];
      end
   end

   logic [31:0] rd_data;

   always_comb
   begin
      rd_data = imc_pkg::ERR_DATA;
      case (apb_req_i.paddr)
         imc_pkg::OFF_CHAN_DRIVE: rd_data = {24'h00_0000, chan_reg};
         imc_pkg::OFF_IN0_MAP: rd_data = {24'h00_0000, map0_reg};
         imc_pkg::OFF_IN1_MAP: rd_data = {24'h00_0000, map1_reg};
         imc_pkg::OFF_IN_LEVEL: rd_data = {30'h0000_0000, in1, in0};
         imc_pkg::OFF_MODE_STAT: rd_data = {27'h000_0000, batt_op, uv_en, bus_ok, mode_next};
         default: rd_data = imc_pkg::ERR_DATA;
      endcase
   end

   // single-wait-state slave: pready one cycle after access begins
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         rdy_reg <= 1'b0;
      else
         rdy_reg <= acc && !rdy_reg;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         apb_rsp_o <= '0;
      else
      begin
         apb_rsp_o.prdata_dummy <= 1'b0;
         apb_rsp_o.pready <= acc && !rdy_reg;
         apb_rsp_o.pslverr <= acc && !rdy_reg && (!mapped || !bus_ok);
         apb_rsp_o.prdata <= (acc && !rdy_reg && bus_ok) ? rd_data : imc_pkg::ERR_DATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel drive
   logic [7:0] demand;
   logic [7:0] default_map;

   assign default_map = (in0 ? imc_pkg::RST_IN0_MAP : 8'h00) | (in1 ? imc_pkg::RST_IN1_MAP : 8'h00);

   always_comb
   begin
      demand = chan_reg | (in0 ? map0_reg : 8'h00) | (in1 ? map1_reg : 8'h00);
      if (mode_next == imc_pkg::MODE_FAILSAFE)
         demand = default_map;
      else if (sleep_req)
         demand = 8'h00;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         chan_drive_o <= 8'h00;
      else if (uv_en && batt_uv)
         chan_drive_o <= 8'h00;
      else if (!batt_op)
         chan_drive_o <= chan_drive_o & demand;
      else
         chan_drive_o <= demand;
   end
endmodule : imc_core

// ---- sim/imc_core_monitor.sv ----
// checker: port assertions of the mapping block
`timescale 1ns/1ps
module imc_core_monitor
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire imc_pkg::imc_apb_req_t apb_req_i,
   input wire imc_pkg::imc_apb_rsp_t apb_rsp_o,
   input wire logic direct_input_0_i,
   input wire logic direct_input_1_i,
   input wire logic low_power_req_i,
   input wire imc_pkg::imc_supply_t supply_i,
   input wire logic [7:0] chan_drive_o,
   input wire imc_pkg::imc_mode_t mode_o,
   input wire logic uv_detect_en_o,
   input wire logic serial_out_en_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   wire slp = !low_power_req_i && !direct_input_0_i && !direct_input_1_i;
   wire lo0 = !low_power_req_i && direct_input_0_i;
   chk_failsafe_entry: assert property (lo0[*5] |-> mode_o == imc_pkg::MODE_FAILSAFE && chan_drive_o[2])
      else $error("fail-safe not entered");
   chk_sleep_entry: assert property (slp[*5] |-> mode_o == imc_pkg::MODE_SLEEP && chan_drive_o == 8'h00)
      else $error("sleep not entered");
   chk_uv_detect_off: assert property (slp[*5] |-> !uv_detect_en_o)
      else $error("uv detect on in sleep");
   chk_serial_off: assert property (slp[*5] |-> !serial_out_en_o)
      else $error("serial out on in sleep");
   chk_sleep_refuse: assert property (slp[*5] ##0 apb_rsp_o.pready |-> apb_rsp_o.pslverr)
      else $error("bus served in sleep");
   chk_logic_uv_refuse: assert property ((supply_i.logic_uv && low_power_req_i)[*5] ##0 apb_rsp_o.pready
      |-> apb_rsp_o.pslverr)
      else $error("bus served in logic uv");
   chk_batt_uv_off: assert property (supply_i.batt_uv[*5] |-> chan_drive_o == 8'h00)
      else $error("channel on in battery uv");
   chk_batt_hold: assert property ((!supply_i.batt_op)[*5] |=> (chan_drive_o & ~$past(chan_drive_o)) == 8'h00)
      else $error("channel switched on below threshold");
   cover property (mode_o == imc_pkg::MODE_FAILSAFE);
   cover property (mode_o == imc_pkg::MODE_SLEEP);
   cover property (apb_rsp_o.pready && apb_rsp_o.pslverr);
endmodule : imc_core_monitor

// ---- sim/imc_host_pins.sv ----
// host pin model: direct inputs and low-power request
`timescale 1ns/1ps
module imc_host_pins #(parameter int HOLD = 4)
(
   input wire logic clk_sys_i,
   input wire logic [2:0] want_i,
   output logic [2:0] pins_o
);
   int cnt = 0;
   initial pins_o = 3'b100;
   always @(posedge clk_sys_i)
   begin
      cnt <= (cnt < HOLD) ? cnt + 1 : cnt;
      if (want_i != pins_o && (cnt >= HOLD || want_i[2] == pins_o[2]))
      begin
         pins_o <= want_i;
         if (want_i[2] != pins_o[2])
            cnt <= 0;
      end
   end
endmodule : imc_host_pins

// ---- sim/imc_core_tb_top.sv ----
// testbench: mapping, modes and supply gating
`timescale 1ns/1ps
module imc_core_tb_top;
   logic clk_sys_i = 0;
   logic rst_i = 1;
   imc_pkg::imc_apb_req_t req = '0;
   imc_pkg::imc_apb_rsp_t rsp;
   imc_pkg::imc_supply_t sup = 3'b010;
   logic [2:0] pw = 3'b100;
   logic [2:0] pins;
   logic [7:0] ch;
   imc_pkg::imc_mode_t md;
   logic uve;
   int err_count = 0;
   int cmp_count = 0;
   logic [31:0] seed = 32'h4D28;
   always #20 clk_sys_i = ~clk_sys_i;
   imc_host_pins host (.clk_sys_i(clk_sys_i), .want_i(pw), .pins_o(pins));
   imc_core dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .apb_req_i(req), .apb_rsp_o(rsp),
      .direct_input_0_i(pins[0]), .direct_input_1_i(pins[1]), .low_power_req_i(pins[2]), .supply_i(sup),
      .chan_drive_o(ch), .mode_o(md), .uv_detect_en_o(uve), .serial_out_en_o());
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [7:0] exp_ch(input logic [31:0] r);
      return r[7:0] | (r[24] ? r[15:8] : 8'h00) | (r[25] ? r[23:16] : 8'h00);
   endfunction : exp_ch
   task end_of_test;
      if (err_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x)
      begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
         err_count++;
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys_i);
      req.penable <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (rsp.pready !== 1'b1 && n < 20);
      q = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
      if (n >= 20)
      begin
         err_count++;
         end_of_test;
      end
   endtask : apb
   task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask : rd
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, {24'h0, d}, q, e);
      repeat (5) @(posedge clk_sys_i);
   endtask : wr
   task pin(input logic [2:0] v);
      pw <= v;
      repeat (12) @(posedge clk_sys_i);
   endtask : pin
   task supw(input logic [2:0] v);
      sup <= v;
      repeat (5) @(posedge clk_sys_i);
   endtask : supw
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(8'h00, 32'h0, 1'b0);
      rd(8'h04, 32'h4, 1'b0);
      rd(8'h08, 32'h8, 1'b0);
      rd(8'h10, 32'h1C, 1'b0);
      rd(8'h14, 32'h0, 1'b1);
      pin(3'b101);
      chk(ch, 32'h4);
      pin(3'b110);
      chk(ch, 32'h8);
      repeat (6)
      begin
         seed = xs(seed);
         wr(8'h00, seed[7:0]);
         wr(8'h04, seed[15:8]);
         wr(8'h08, seed[23:16]);
         pin({1'b1, seed[25:24]});
         rd(8'h04, {24'h0, seed[15:8]}, 1'b0);
         chk(ch, exp_ch(seed));
         rd(8'h0C, {30'h0, seed[25:24]}, 1'b0);
      end
      pin(3'b001);
      chk(md, 32'h2);
      chk(ch, 32'h4);
      rd(8'h0C, 32'h1, 1'b0);
      wr(8'h00, 8'hFF);
      rd(8'h00, 32'h0, 1'b0);
      pin(3'b000);
      chk(md, 32'h1);
      chk(uve, 32'h0);
      rd(8'h0C, 32'h0, 1'b1);
      pin(3'b100);
      rd(8'h04, 32'h4, 1'b0);
      wr(8'h00, 8'hF0);
      supw(3'b110);
      chk(ch, 32'h0);
      supw(3'b010);
      chk(ch, 32'hF0);
      supw(3'b000);
      wr(8'h00, 8'hFF);
      chk(ch, 32'hF0);
      wr(8'h00, 8'h30);
      chk(ch, 32'h30);
      supw(3'b111);
      chk(ch, 32'h0);
      rd(8'h00, 32'h0, 1'b1);
      supw(3'b011);
      rd(8'h00, 32'h0, 1'b1);
      supw(3'b010);
      rd(8'h00, 32'h0, 1'b0);
      end_of_test;
   end
endmodule : imc_core_tb_top
bind imc_core imc_core_monitor mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .apb_req_i(apb_req_i),
   .apb_rsp_o(apb_rsp_o), .direct_input_0_i(direct_input_0_i), .direct_input_1_i(direct_input_1_i),
   .low_power_req_i(low_power_req_i), .supply_i(supply_i), .chan_drive_o(chan_drive_o), .mode_o(mode_o),
   .uv_detect_en_o(uv_detect_en_o), .serial_out_en_o(serial_out_en_o));
